// ==== src/uef_pkg.sv ====
// Purpose: shared constants for the endpoint fifo access block
// Assumes: 10 MHz core clock, 32-bit apb data, one word per register
// Notes:   register offsets are byte addresses
package uef_pkg;
  // apb register byte offsets
  localparam logic [7:0] CMD_STATUS_OFF = 8'h00;
  localparam logic [7:0] DIR_TOGGLE_OFF = 8'h04;
  localparam logic [7:0] EP_SELECT_OFF  = 8'h08;
  localparam logic [7:0] DATA_PORT0_OFF = 8'h10; // ports 0..5 follow at 4-byte steps
  localparam int         NUM_EP         = 6;

  // command/status field positions
  localparam int ZLEN_BIT  = 7;
  localparam int READY_BIT = 6;
  localparam int SETUP_BIT = 5;
  localparam int CLEAR_BIT = 2;
  localparam int TX_BIT    = 1;
  localparam int REQ_BIT   = 0;

  // reset values
  localparam logic [7:0] CMD_STATUS_RST = 8'h00;
  localparam logic [5:0] PIPE_DIR_RST   = 6'h3E; // endpoints 1..5 start as in pipes
  localparam logic [2:0] EP_SELECT_RST  = 3'h0;

  // fifo depths and transfer kinds
  localparam int SMALL_DEPTH = 8;
  localparam int LARGE_DEPTH = 64;
  localparam logic [5:0] BULK_EP_MASK = 6'h28; // endpoints 3 and 5 carry bulk, rest interrupt

  // timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int PULSE_MIN_NS     = 2000;
  localparam int PULSE_MIN_CYCLES = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    UEF_IDLE  = 2'b00,
    UEF_READ  = 2'b01,
    UEF_WRITE = 2'b10
  } uef_xfer_t;

  function automatic int uef_depth(input int ep);
    return BULK_EP_MASK[ep] ? LARGE_DEPTH : SMALL_DEPTH;
  endfunction
endpackage

// ==== src/uef_fifo.sv ====
// Purpose: one endpoint byte buffer with flush
// Assumes: caller never pushes when full or pops when empty
// Notes:   read data is the head byte, valid while not empty
`timescale 1ns/1ns
module uef_fifo
  import uef_pkg::*;
#(
  parameter int DEPTH = SMALL_DEPTH
)(
  input  wire logic       core_clk_in, // core clock
  input  wire logic       rst_in,      // async reset, active high
  input  wire logic       flush_in,    // empty the buffer
  input  wire logic       push_in,     // store wdata_in
  input  wire logic [7:0] wdata_in,    // byte to store
  input  wire logic       pop_in,      // drop head byte
  output logic      [7:0] rdata_out,   // head byte
  output logic            full_out,    // no room left
  output logic            empty_out    // nothing stored
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0]  mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;

  // storage has no reset, contents are unknown until written
  always_ff @(posedge core_clk_in)
  begin
    if (push_in)
      mem[wr_ptr_reg[AW-1:0]] <= wdata_in;
  end

  // pointers carry one extra bit so full and empty differ
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else if (flush_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push_in)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop_in)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  assign rdata_out = mem[rd_ptr_reg[AW-1:0]];
  assign empty_out = (wr_ptr_reg == rd_ptr_reg);
  assign full_out  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
endmodule

// ==== src/uef_pulse_qual.sv ====
// Purpose: accept a software pulse only if it stood high long enough
// Assumes: level_in comes from a register bit
// Notes:   fires one cycle on the falling edge of a long enough pulse
`timescale 1ns/1ns
module uef_pulse_qual
  import uef_pkg::*;
#(
  parameter int MIN_CYCLES = PULSE_MIN_CYCLES
)(
  input  wire logic core_clk_in, // core clock
  input  wire logic rst_in,      // async reset, active high
  input  wire logic level_in,    // software controlled bit
  output logic      fire_out     // one-cycle accept pulse
);
  localparam int CW = $clog2(MIN_CYCLES + 1);
  localparam logic [CW-1:0] MIN_CNT = CW'(MIN_CYCLES);
  logic [CW-1:0] high_cnt_reg;
  logic          level_d_reg;

  // saturating count of cycles spent high, restarts when low
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      high_cnt_reg <= '0;
      level_d_reg  <= 1'b0;
    end
    else
    begin
      level_d_reg <= level_in;
      if (!level_in)
        high_cnt_reg <= '0;
      else if (high_cnt_reg != MIN_CNT)
        high_cnt_reg <= high_cnt_reg + 1'b1;
    end
  end

  // short glitches are ignored so a stray write cannot flush data
  assign fire_out = level_d_reg && !level_in && (high_cnt_reg == MIN_CNT);
endmodule

// ==== src/uef_top.sv ====
// Purpose: mcu side access to six usb endpoint fifos over apb
// Assumes: sie side strobes are single-cycle and respect full/empty
// Notes:   apb answers with no wait states beyond the setup cycle
//
// Behaviour
// - a usb bus reset clears the whole command/status register
// - zero-length flag sets on empty ep0 packet; cleared by software or next setup
// - bit 6 reads one when the requested fifo can be operated
// - setup flag set by hardware, cleared only by software or a usb bus reset
// - bits 4 and 3 read zero and do nothing
// - a 2us clear pulse then zero empties the requested fifo
// - bit 1 low means mcu reads, high means mcu writes
// - next byte and status appear within 2us after each data access
// - read check: 00h, 01h, wait, read 41h or 01h, then 00h
// - write check: 02h, 03h, wait, read 43h or 03h, then 02h
// - read bytes until 01h, then 03h and 02h close the read
// - write bytes until 03h, then 01h and 00h release the packet
// - empty ep0 packet shows 81h, clearing flag leaves 01h
// - write close with no bytes sends an empty packet
// - direction bits 5..1 set in pipes, clear out pipes, reset to in
// - a 2us data-toggle pulse forces data0 on the next packet
// - 8-byte fifos on 0,1,2,4 and 64-byte on 3,5, own ports
// - interrupt transfers on 0,1,2,4, bulk on 3 and 5
`timescale 1ns/1ns
module uef_top
  import uef_pkg::*;
(
  input  wire logic        core_clk_in,        // core clock, 10 MHz
  input  wire logic        rst_in,             // async reset, active high
  input  wire logic        psel_in,            // apb select
  input  wire logic        penable_in,         // apb access phase
  input  wire logic        pwrite_in,          // apb direction
  input  wire logic [7:0]  paddr_in,           // apb byte address
  input  wire logic [31:0] pwdata_in,          // apb write data
  output logic             pready_out,         // apb ready
  output logic [31:0]      prdata_out,         // apb read data
  output logic             pslverr_out,        // apb error, unmapped address
  input  wire logic        usb_reset_in,       // usb bus reset seen
  input  wire logic        setup_rx_in,        // valid setup packet stored in ep0
  input  wire logic        zlp_rx_in,          // empty out packet received on ep0
  input  wire logic        sie_push_in,        // sie stores a received byte
  input  wire logic        sie_pop_in,         // sie takes a byte to send
  input  wire logic [2:0]  sie_ep_in,          // endpoint for push/pop/sent
  input  wire logic [7:0]  sie_wdata_in,       // received byte
  input  wire logic        sie_sent_in,        // sie finished sending a packet
  output logic [7:0]       sie_rdata_out,      // byte taken by last pop
  output logic [5:0]       in_pkt_ready_out,   // packet committed per endpoint
  output logic [5:0]       pipe_dir_in_out,    // high: in pipe
  output logic [5:0]       bulk_ep_out,        // high: bulk, low: interrupt
  output logic             force_data0_out     // next packet uses data0
);
  logic [7:0]  cmd_reg;
  logic [5:0]  pipe_dir_reg;
  logic        toggle_bit_reg;
  logic [2:0]  ep_sel_reg;
  logic        ready_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic [7:0]  sie_rdata_reg;
  logic [5:0]  in_pkt_reg;
  logic        force_data0_reg;
  logic [5:0]  bulk_ep_reg;
  uef_xfer_t   xfer_reg;

  logic        apb_done;
  logic        wr_cmd;
  logic        wr_data;
  logic        rd_data;
  logic [2:0]  port_ep;
  logic        port_hit;
  logic        clear_fire;
  logic        toggle_fire;
  logic        close_write;
  logic        close_read;
  logic [7:0]  next_cmd;
  logic [5:0]  fifo_full;
  logic [5:0]  fifo_empty;
  logic [7:0]  fifo_rdata [NUM_EP];

  // apb decode; a transfer completes on the access edge with pready high
  assign apb_done = psel_in && penable_in && pready_reg;
  assign port_ep  = 3'((paddr_in - DATA_PORT0_OFF) >> 2);
  assign port_hit = (paddr_in >= DATA_PORT0_OFF) && (paddr_in < DATA_PORT0_OFF + 8'h18) && (paddr_in[1:0] == 2'h0);
  assign wr_cmd   = apb_done && pwrite_in && (paddr_in == CMD_STATUS_OFF);
  assign wr_data  = apb_done && pwrite_in && port_hit && cmd_reg[REQ_BIT] && cmd_reg[TX_BIT];
  assign rd_data  = apb_done && !pwrite_in && port_hit && cmd_reg[REQ_BIT] && !cmd_reg[TX_BIT]
                    && !fifo_empty[port_ep];

  // end of transfer is the direction flip while the request still stands
  assign close_write = wr_cmd && cmd_reg[REQ_BIT] && cmd_reg[TX_BIT] && !pwdata_in[TX_BIT];
  assign close_read  = wr_cmd && cmd_reg[REQ_BIT] && !cmd_reg[TX_BIT] && pwdata_in[TX_BIT];

  // qualifiers for the two software pulses
  uef_pulse_qual #(.MIN_CYCLES(PULSE_MIN_CYCLES)) u_clear_q (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .level_in    (cmd_reg[CLEAR_BIT]),
    .fire_out    (clear_fire)
  );
  uef_pulse_qual #(.MIN_CYCLES(PULSE_MIN_CYCLES)) u_toggle_q (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .level_in    (toggle_bit_reg),
    .fire_out    (toggle_fire)
  );

  // one buffer per endpoint; mcu and sie never own the same one at once
  generate
    for (genvar e = 0; e < NUM_EP; e++)
    begin : g_ep
      logic flush;
      logic push;
      logic pop;
      logic [7:0] wdata;
      // clear flushes whatever is requested, ready or not
      assign flush = (clear_fire && ep_sel_reg == 3'(e))
                     || (close_read && ep_sel_reg == 3'(e));
      assign push  = (wr_data && port_ep == 3'(e) && !fifo_full[e]) || (sie_push_in && sie_ep_in == 3'(e));
      assign pop   = (rd_data && port_ep == 3'(e)) || (sie_pop_in && sie_ep_in == 3'(e));
      assign wdata = wr_data ? pwdata_in[7:0] : sie_wdata_in;
      uef_fifo #(.DEPTH(uef_depth(e))) u_fifo (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .flush_in    (flush),
        .push_in     (push),
        .wdata_in    (wdata),
        .pop_in      (pop),
        .rdata_out   (fifo_rdata[e]),
        .full_out    (fifo_full[e]),
        .empty_out   (fifo_empty[e])
      );
    end
  endgenerate

  // next command/status value: software write, then hardware sets and clears on top
  always_comb
  begin
    next_cmd = cmd_reg;
    if (wr_cmd)
    begin
      next_cmd[CLEAR_BIT] = pwdata_in[CLEAR_BIT];
      next_cmd[TX_BIT]    = pwdata_in[TX_BIT];
      next_cmd[REQ_BIT]   = pwdata_in[REQ_BIT];
      if (!pwdata_in[ZLEN_BIT])
        next_cmd[ZLEN_BIT] = 1'b0;
      if (!pwdata_in[SETUP_BIT])
        next_cmd[SETUP_BIT] = 1'b0;
    end
    if (setup_rx_in)
      next_cmd[ZLEN_BIT] = 1'b0;
    if (zlp_rx_in)
      next_cmd[ZLEN_BIT] = 1'b1;
    if (setup_rx_in)
      next_cmd[SETUP_BIT] = 1'b1;
    next_cmd[READY_BIT] = 1'b0;
    next_cmd[4:3]       = 2'b00;
  end

  // command/status register; usb reset wipes it like a power-up
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      cmd_reg <= CMD_STATUS_RST;
    else if (usb_reset_in)
      cmd_reg <= CMD_STATUS_RST;
    else
      cmd_reg <= next_cmd;
  end

  // readiness is recomputed every cycle, far inside the 2us window
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      ready_reg <= 1'b0;
    else if (usb_reset_in)
      ready_reg <= 1'b0;
    else if (!next_cmd[REQ_BIT])
      ready_reg <= 1'b0;
    else if (next_cmd[TX_BIT])
      ready_reg <= !in_pkt_reg[ep_sel_reg] && !fifo_full[ep_sel_reg]
                   && !(wr_data && port_ep == ep_sel_reg);
    else
      ready_reg <= !fifo_empty[ep_sel_reg] && !rd_data;
  end

  // transfer state, kept for visibility of the request phase
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      xfer_reg <= UEF_IDLE;
    else if (!next_cmd[REQ_BIT] || usb_reset_in)
      xfer_reg <= UEF_IDLE;
    else
    begin
      case (next_cmd[TX_BIT])
        1'b0:    xfer_reg <= UEF_READ;
        1'b1:    xfer_reg <= UEF_WRITE;
        default: xfer_reg <= UEF_IDLE;
      endcase
    end
  end

  // direction, toggle and endpoint select registers
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pipe_dir_reg   <= PIPE_DIR_RST;
      toggle_bit_reg <= 1'b0;
      ep_sel_reg     <= EP_SELECT_RST;
    end
    else if (apb_done && pwrite_in)
    begin
      if (paddr_in == DIR_TOGGLE_OFF)
      begin
        pipe_dir_reg   <= {pwdata_in[5:1], 1'b0};
        toggle_bit_reg <= pwdata_in[0];
      end
      if (paddr_in == EP_SELECT_OFF && pwdata_in[2:0] < 3'(NUM_EP))
        ep_sel_reg <= pwdata_in[2:0];
    end
  end

  // committed in packets; an empty commit still sends a zero-length packet
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      in_pkt_reg <= '0;
    else
    begin
      for (int e = 0; e < NUM_EP; e++)
      begin
        if (close_write && ep_sel_reg == 3'(e))
          in_pkt_reg[e] <= 1'b1;
        else if (sie_sent_in && sie_ep_in == 3'(e))
          in_pkt_reg[e] <= 1'b0;
      end
    end
  end

  // data0 stays forced until the sie has sent one packet
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      force_data0_reg <= 1'b0;
    else if (toggle_fire)
      force_data0_reg <= 1'b1;
    else if (sie_sent_in)
      force_data0_reg <= 1'b0;
  end

  // apb answer, registered; unmapped addresses give pslverr
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= psel_in && !penable_in;
      pslverr_reg <= psel_in && !penable_in && !(port_hit || paddr_in == CMD_STATUS_OFF
                     || paddr_in == DIR_TOGGLE_OFF || paddr_in == EP_SELECT_OFF);
      prdata_reg  <= '0;
      if (psel_in && !penable_in && !pwrite_in)
      begin
        if (paddr_in == CMD_STATUS_OFF)
          prdata_reg[7:0] <= {cmd_reg[7], ready_reg, cmd_reg[5], 2'b00, cmd_reg[2:0]};
        else if (paddr_in == DIR_TOGGLE_OFF)
          prdata_reg[7:0] <= {2'b00, pipe_dir_reg[5:1], toggle_bit_reg};
        else if (paddr_in == EP_SELECT_OFF)
          prdata_reg[7:0] <= {5'h00, ep_sel_reg};
        else if (port_hit)
          prdata_reg[7:0] <= fifo_rdata[port_ep];
      end
    end
  end

  // sie read byte is captured as it is popped
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      sie_rdata_reg <= '0;
    else if (sie_pop_in && sie_ep_in < 3'(NUM_EP))
      sie_rdata_reg <= fifo_rdata[sie_ep_in];
  end

  // transfer kind is fixed per endpoint, exposed for the sie from a flop
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      bulk_ep_reg <= 6'h00;
    else
      bulk_ep_reg <= BULK_EP_MASK;
  end

  assign pready_out       = pready_reg;
  assign prdata_out       = prdata_reg;
  assign pslverr_out      = pslverr_reg;
  assign sie_rdata_out    = sie_rdata_reg;
  assign in_pkt_ready_out = in_pkt_reg;
  assign pipe_dir_in_out  = pipe_dir_reg;
  assign bulk_ep_out      = bulk_ep_reg;
  assign force_data0_out  = force_data0_reg;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_write_close;
    wr_cmd && cmd_reg[REQ_BIT] && cmd_reg[TX_BIT] && !pwdata_in[TX_BIT];
  endsequence

  usb_reset_clear_a: assert property (usb_reset_in |=> cmd_reg == 8'h00 && !ready_reg)
    else $error("usb reset did not clear command register");
  zlen_set_a: assert property (zlp_rx_in |=> cmd_reg[ZLEN_BIT])
    else $error("zero-length flag not set");
  ready_req_a: assert property (!cmd_reg[REQ_BIT] && !$past(cmd_reg[REQ_BIT]) |-> !ready_reg)
    else $error("ready without request");
  setup_hold_a: assert property (cmd_reg[SETUP_BIT] && !wr_cmd && !usb_reset_in |=> cmd_reg[SETUP_BIT])
    else $error("setup flag cleared by hardware");
  unused_bits_a: assert property (cmd_reg[4:3] == 2'b00 && prdata_reg[31:8] == 24'h0)
    else $error("unused bits not zero");
  read_empty_a: assert property (rd_data |=> !ready_reg)
    else $error("ready kept after a data read");
  ready_xfer_a: assert property (ready_reg |-> xfer_reg == (cmd_reg[TX_BIT] ? UEF_WRITE : UEF_READ))
    else $error("ready without matching transfer state");
  write_commit_a: assert property ((s_write_close and !usb_reset_in) |=> in_pkt_reg[ep_sel_reg])
    else $error("write close did not commit packet");
  toggle_force_a: assert property (toggle_fire |=> force_data0_reg)
    else $error("data0 not forced");
  apb_answer_a: assert property (psel_in && !penable_in |=> pready_reg)
    else $error("apb answer late");
endmodule

// ==== bench/uef_sie_model.sv ====
// Purpose: usb engine side model that fills and drains endpoint buffers
// Assumes: the bench calls one task at a time; counts stay within depth
// Notes:   an idle data line shows the inverse of the last byte, not a stale copy
`timescale 1ns/1ns
module uef_sie_model (
  input  wire logic       clk_in,    // core clock
  input  wire logic [7:0] rdata_in,  // byte taken by a pop
  output logic            push_out,  // store a byte
  output logic            pop_out,   // take a byte
  output logic [2:0]      ep_out,    // endpoint addressed
  output logic [7:0]      wdata_out, // byte to store
  output logic [3:0]      ev_out     // usb reset, setup, empty packet, sent
);
  // quiet lines at time zero
  initial
  begin
    push_out = 1'b0;
    pop_out = 1'b0;
    ep_out = 3'h0;
    wdata_out = 8'hA5;
    ev_out = 4'h0;
  end

  // one received byte into an endpoint buffer
  task automatic push(input logic [2:0] ep, input logic [7:0] d);
    @(posedge clk_in);
    push_out <= 1'b1;
    ep_out <= ep;
    wdata_out <= d;
    @(posedge clk_in);
    push_out <= 1'b0;
    wdata_out <= ~d;
  endtask

  // take one byte to send; the byte shows one edge after the strobe
  task automatic pop(input logic [2:0] ep, output logic [7:0] d);
    @(posedge clk_in);
    pop_out <= 1'b1;
    ep_out <= ep;
    @(posedge clk_in);
    pop_out <= 1'b0;
    @(posedge clk_in);
    d = rdata_in;
  endtask

  // single-cycle bus event: 0 reset, 1 setup, 2 empty packet, 3 packet sent
  task automatic ev(input int k, input logic [2:0] ep);
    @(posedge clk_in);
    ev_out <= 4'(1 << k);
    ep_out <= ep;
    @(posedge clk_in);
    ev_out <= 4'h0;
  endtask
endmodule

// ==== bench/test_usb_endpoint_fifo_access.sv ====
// Purpose: self-checking bench for the endpoint buffer access block
// Assumes: zero-wait apb slave; firmware leaves 2us after requests and data accesses
// Notes:   expectations come from the status codes of the access flows
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module test_usb_endpoint_fifo_access;
  import uef_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, force0;
  logic [7:0]  paddr, srd, swd;
  logic [31:0] pwdata, prdata;
  logic [2:0]  sep;
  logic [3:0]  sev;
  logic [5:0]  pkt, pipes, bulk;
  logic        spush, spop;
  int          failures, total_checks;

  uef_top uef_top_inst (.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .usb_reset_in(sev[0]), .setup_rx_in(sev[1]), .zlp_rx_in(sev[2]),
    .sie_push_in(spush), .sie_pop_in(spop), .sie_ep_in(sep), .sie_wdata_in(swd), .sie_sent_in(sev[3]),
    .sie_rdata_out(srd), .in_pkt_ready_out(pkt), .pipe_dir_in_out(pipes), .bulk_ep_out(bulk),
    .force_data0_out(force0));
  uef_sie_model sie_model_inst (.clk_in(clk), .rdata_in(srd), .push_out(spush), .pop_out(spop),
    .ep_out(sep), .wdata_out(swd), .ev_out(sev));

  // free-running 10 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic print_verdict;
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      failures++;
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(n, {24'h0, x}, r)
  endtask

  // firmware spacing between accesses and after a request
  task automatic gap;
    repeat (PULSE_MIN_CYCLES) @(posedge clk);
  endtask

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rdc("status", CMD_STATUS_OFF, 8'h00);
    rdc("direction", DIR_TOGGLE_OFF, 8'h3E);
    `CHK("pipes", 6'h3E, pipes)
    `CHK("bulk", 6'h28, bulk)
    apb(1'b0, 8'hFC, 32'h0, r, e);
    `CHK("unmapped", 1'b1, e)
  endtask

  // read check on an empty buffer, then a three-byte read
  task automatic t_read;
    logic [7:0] b [3];
    b = '{8'hA1, 8'h5C, 8'h3E};
    wr(EP_SELECT_OFF, 8'h01);
    wr(CMD_STATUS_OFF, 8'h00);
    wr(CMD_STATUS_OFF, 8'h01);
    gap();
    rdc("not ready", CMD_STATUS_OFF, 8'h01);
    wr(CMD_STATUS_OFF, 8'h00);
    foreach (b[i]) sie_model_inst.push(3'h1, b[i]);
    wr(CMD_STATUS_OFF, 8'h01);
    gap();
    rdc("ready", CMD_STATUS_OFF, 8'h41);
    foreach (b[i])
    begin
      rdc("byte", DATA_PORT0_OFF + 8'h04, b[i]);
      gap();
    end
    rdc("drained", CMD_STATUS_OFF, 8'h01);
    wr(CMD_STATUS_OFF, 8'h03);
    wr(CMD_STATUS_OFF, 8'h02);
    rdc("closed", CMD_STATUS_OFF, 8'h02);
  endtask

  // fill a buffer to its depth, release the packet and drain it
  task automatic t_fill(input logic [2:0] ep, input int depth);
    logic [7:0] d;
    wr(EP_SELECT_OFF, {5'h0, ep});
    wr(CMD_STATUS_OFF, 8'h02);
    wr(CMD_STATUS_OFF, 8'h03);
    gap();
    for (int i = 0; i < depth; i++)
    begin
      rdc("room", CMD_STATUS_OFF, 8'h43);
      wr(DATA_PORT0_OFF + 8'(4 * ep), 8'(i * 7 + ep + 1));
      gap();
    end
    rdc("full", CMD_STATUS_OFF, 8'h03);
    wr(CMD_STATUS_OFF, 8'h01);
    wr(CMD_STATUS_OFF, 8'h00);
    `CHK("packet", 1'b1, pkt[ep])
    for (int i = 0; i < depth; i++)
    begin
      sie_model_inst.pop(ep, d);
      `CHK("sent byte", 8'(i * 7 + ep + 1), d)
    end
    sie_model_inst.ev(3, ep);
  endtask

  // empty packet flag, setup flag and bus reset
  task automatic t_flags;
    wr(EP_SELECT_OFF, 8'h00);
    wr(CMD_STATUS_OFF, 8'h00);
    wr(CMD_STATUS_OFF, 8'h01);
    // the empty packet lands while the read request stands; a command write would wipe it
    sie_model_inst.ev(2, 3'h0);
    gap();
    rdc("empty packet", CMD_STATUS_OFF, 8'h81);
    wr(CMD_STATUS_OFF, 8'h01);
    rdc("flag cleared", CMD_STATUS_OFF, 8'h01);
    wr(CMD_STATUS_OFF, 8'h03);
    wr(CMD_STATUS_OFF, 8'h02);
    sie_model_inst.ev(2, 3'h0);
    sie_model_inst.ev(1, 3'h0);
    gap();
    rdc("setup", CMD_STATUS_OFF, 8'h22);
    wr(CMD_STATUS_OFF, 8'h02);
    rdc("setup cleared", CMD_STATUS_OFF, 8'h02);
    sie_model_inst.ev(1, 3'h0);
    sie_model_inst.ev(0, 3'h0);
    rdc("bus reset", CMD_STATUS_OFF, 8'h00);
  endtask

  // clear pulse empties a buffer that still holds data
  task automatic t_clear;
    sie_model_inst.push(3'h4, 8'h9D);
    sie_model_inst.push(3'h4, 8'h62);
    wr(EP_SELECT_OFF, 8'h04);
    wr(CMD_STATUS_OFF, 8'h01);
    gap();
    wr(CMD_STATUS_OFF, 8'h1D);
    rdc("unused bits", CMD_STATUS_OFF, 8'h45);
    gap();
    wr(CMD_STATUS_OFF, 8'h01);
    repeat (3) @(posedge clk);
    rdc("cleared", CMD_STATUS_OFF, 8'h01);
    wr(CMD_STATUS_OFF, 8'h03);
    wr(CMD_STATUS_OFF, 8'h02);
  endtask

  // empty packet, data toggle pulse and pipe directions
  task automatic t_toggle;
    wr(EP_SELECT_OFF, 8'h02);
    wr(CMD_STATUS_OFF, 8'h02);
    wr(CMD_STATUS_OFF, 8'h03);
    gap();
    wr(CMD_STATUS_OFF, 8'h01);
    wr(CMD_STATUS_OFF, 8'h00);
    `CHK("empty commit", 1'b1, pkt[2])
    wr(DIR_TOGGLE_OFF, 8'h3F);
    gap();
    wr(DIR_TOGGLE_OFF, 8'h00);
    repeat (3) @(posedge clk);
    `CHK("data0", 1'b1, force0)
    `CHK("out pipes", 6'h00, pipes)
    rdc("direction", DIR_TOGGLE_OFF, 8'h00);
    sie_model_inst.ev(3, 3'h2);
    @(posedge clk);
    `CHK("data0 used", 1'b0, force0)
    `CHK("packet gone", 1'b0, pkt[2])
  endtask

  // main sequence
  initial
  begin
    failures = 0;
    total_checks = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_read();
    t_fill(3'h0, SMALL_DEPTH);
    t_fill(3'h3, LARGE_DEPTH);
    t_flags();
    t_clear();
    t_toggle();
    print_verdict();
  end
endmodule
